// ---- core/dcc_pkg.sv ----
/*
  shared constants, encodings and carrier types of the dual comparator control block.
  assumes a 32-bit apb master and analog comparators whose mux selects are driven from here.
*/
package dcc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register map: printed offsets are indices, byte address is four times the index
  localparam logic [11:0] CTL_INDEX = 12'h01f; // comparator_control
  localparam logic [11:0] DIR_INDEX = 12'h085; // port_a_direction
  localparam logic [11:0] FLAG_INDEX = 12'h040; // change flag
  localparam logic [11:0] IEN_INDEX = 12'h041; // interrupt enables
  localparam int unsigned BYTES_PER_REG = 4;

  // register selector codes
  typedef enum logic [2:0] {SEL_NONE = 3'h0, SEL_CTL = 3'h1, SEL_DIR = 3'h2, SEL_FLAG = 3'h3, SEL_IEN = 3'h4} dcc_sel_e;

  ////////////////////////////////////////////////////////////////////////////////
  // control, direction, flag and interrupt enable register fields
  localparam int unsigned CTL_CMP2_BIT = 7;
  localparam int unsigned CTL_CMP1_BIT = 6;
  localparam int unsigned CTL_CIS_BIT = 3;
  localparam int unsigned CTL_MODE_LSB = 0;
  localparam int unsigned MODE_W = 3;
  localparam int unsigned DIR_W = 5;
  localparam logic [DIR_W-1:0] DIR_RST = 5'h1f;
  localparam int unsigned FLAG_BIT = 0;
  localparam int unsigned IEN_CMP_BIT = 0;
  localparam int unsigned IEN_PER_BIT = 1;
  localparam int unsigned IEN_GLB_BIT = 2;

  // comparator operating modes
  typedef enum logic [2:0]
  {
    MODE_RESET = 3'h0,
    MODE_MUX3 = 3'h1,
    MODE_VREF4 = 3'h2,
    MODE_COMMON = 3'h3,
    MODE_INDEP = 3'h4,
    MODE_ONE = 3'h5,
    MODE_OUTPIN = 3'h6,
    MODE_OFF = 3'h7
  } dcc_mode_e;

  // comparator input source codes
  localparam logic [2:0] SRC_PIN0 = 3'h0;
  localparam logic [2:0] SRC_PIN1 = 3'h1;
  localparam logic [2:0] SRC_PIN2 = 3'h2;
  localparam logic [2:0] SRC_PIN3 = 3'h3;
  localparam logic [2:0] SRC_VREF = 3'h4;
  localparam logic [2:0] SRC_OPEN = 3'h7;

  ////////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } dcc_apb_req_s;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } dcc_apb_rsp_s;

  typedef struct packed {
    logic [2:0] c1Inv;
    logic [2:0] c1NonInv;
    logic [2:0] c2Inv;
    logic [2:0] c2NonInv;
    logic [1:0] cmpPowerEn;
    logic [3:0] analogPinEn;
    logic [1:0] pinCmpOutSel;
  } dcc_mux_s;

  localparam dcc_mux_s MUX_RST = '{SRC_OPEN, SRC_OPEN, SRC_OPEN, SRC_OPEN, 2'h0, 4'hf, 2'h0};

endpackage

// ---- core/dcc_sync.sv ----
/*
  two-flop synchroniser for the raw comparator results.
  assumes the inputs are asynchronous to core_clk; only stage two is read outside.
*/
`timescale 1ns/10ps
`default_nettype none
module dcc_sync
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // raw and synchronised results
  input wire logic [1:0] rawIn,
  output logic [1:0] syncOut
);

  // both stages held in one struct
  typedef struct packed {
    logic [1:0] stage1;
    logic [1:0] stage2;
  } dcc_sync_s;

  dcc_sync_s s_q; // registered stages
  dcc_sync_s s_d; // next stages

  ////////////////////////////////////////////////////////////////////////////////
  // shift the raw bits through both stages, one bit per loop pass
  always_comb
  begin
    s_d = s_q;
    for (int i = 0; i < 2; i++)
    begin
      s_d.stage1[i] = rawIn[i];
      s_d.stage2[i] = s_q.stage1[i];
    end
  end

  // register both stages
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign syncOut = s_q.stage2;

endmodule
`default_nettype wire

// ---- core/dcc_top.sv ----
/*
  dual comparator control: mode and input-switch register, result bits, change detection,
  port direction register and analog mux steering, reached over a zero-wait apb slave.
  assumes analog comparators and pad muxes outside; raw results arrive asynchronously.
*/
// The APB interface to the registers was decided locally.
//
// Summary of operation
// [R1] control register at index 1Fh, eight bits
// [R2] bit 7 shows comparator two, read only
// [R3] bit 6 shows comparator one, read only
// [R4] bits 5 and 4 always read zero
// [R5] mode 001: switch picks pin3 or pin0
// [R6] mode 010: switch picks pins 3,2 or 0,1
// [R7] three mode bits pick eight mux configurations
// [R8] comparator inputs shared with pins 0..3, vref
// [R9] direction register still steers pins every mode
// [R10] software ignores results while mode settles
// [R11] software masks interrupts during mode change
// [R12] mode 011: pins 0,1 inverting, pin2 common
// [R13] control read ends pending change condition
// [R14] mismatch against latched value keeps setting flag
// [R15] request needs three enables; flag always sets
// [R16] reset clears control, mode 000, comparators off
// [R17] mode 110 routes raw results to pins 3,4
// [R18] any control access latches reference results
// [R19] results pass two flip-flops before use
`timescale 1ns/10ps
`default_nettype none
module dcc_top
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // apb slave
  input wire dcc_pkg::dcc_apb_req_s apbReq,
  output dcc_pkg::dcc_apb_rsp_s apbRsp,
  // raw comparator results from the analog block
  input wire logic cmp1Raw,
  input wire logic cmp2Raw,
  // analog mux and power steering
  output dcc_pkg::dcc_mux_s muxCtl,
  // port pins 0..4 direction and output enables
  output logic [4:0] portDir,
  output logic [4:0] portOutEn,
  // change flag and interrupt request
  output logic cmpChangeFlag,
  output logic cmpIrqReq
);
  import dcc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [MODE_W-1:0] cmpModeSel; // operating mode field
    logic inputSwitchSel; // inverting input switch
    logic [DIR_W-1:0] portADirection; // 1 = input
    logic cmpChangeFlag; // sticky change flag
    logic cmpChangeIrqEn; // comparator enable
    logic peripheralIrqEn; // peripheral enable
    logic globalIrqEn; // global enable
    logic [1:0] refResult; // latched reference results
    logic irqReq; // registered request
    logic [DIR_W-1:0] outEn; // registered pin output enables
    dcc_mux_s mux; // registered mux steering
    dcc_apb_rsp_s rsp; // registered bus answer
  } dcc_state_s;

  localparam dcc_state_s STATE_RST = '{
    cmpModeSel: MODE_RESET,
    inputSwitchSel: 1'b0,
    portADirection: DIR_RST,
    cmpChangeFlag: 1'b0,
    cmpChangeIrqEn: 1'b0,
    peripheralIrqEn: 1'b0,
    globalIrqEn: 1'b0,
    refResult: 2'h0,
    irqReq: 1'b0,
    outEn: 5'h00,
    mux: MUX_RST,
    rsp: '{1'b0, 32'h0000_0000, 1'b0}
  };

  dcc_state_s s_q; // registered state
  dcc_state_s s_d; // next state

  logic [1:0] syncRes; // synchronised results, bit1 = comparator two

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // map a byte address onto a register selector
  function automatic dcc_sel_e regSel(input logic [11:0] addr);
    dcc_sel_e sel;
    sel = SEL_NONE;
    if (addr == 12'(CTL_INDEX * BYTES_PER_REG))
    begin
      sel = SEL_CTL; // R1
    end
    else if (addr == 12'(DIR_INDEX * BYTES_PER_REG))
    begin
      sel = SEL_DIR;
    end
    else if (addr == 12'(FLAG_INDEX * BYTES_PER_REG))
    begin
      sel = SEL_FLAG;
    end
    else if (addr == 12'(IEN_INDEX * BYTES_PER_REG))
    begin
      sel = SEL_IEN;
    end
    return sel;
  endfunction

  // decode mode and input switch into mux steering
  function automatic dcc_mux_s decodeMode(input logic [MODE_W-1:0] mode, input logic input_switch_sel);
    dcc_mux_s m;
    m = MUX_RST;
    unique case (dcc_mode_e'(mode)) // R7 R8
      MODE_RESET:
      begin
        m = MUX_RST; // R16
      end
      MODE_MUX3:
      begin
        m.c1Inv = input_switch_sel ? SRC_PIN3 : SRC_PIN0; // R5
        m.c1NonInv = SRC_PIN2;
        m.c2Inv = SRC_PIN1;
        m.c2NonInv = SRC_PIN2;
        m.cmpPowerEn = 2'h3;
        m.analogPinEn = 4'hf;
      end
      MODE_VREF4:
      begin
        m.c1Inv = input_switch_sel ? SRC_PIN3 : SRC_PIN0; // R6
        m.c2Inv = input_switch_sel ? SRC_PIN2 : SRC_PIN1; // R6
        m.c1NonInv = SRC_VREF;
        m.c2NonInv = SRC_VREF;
        m.cmpPowerEn = 2'h3;
        m.analogPinEn = 4'hf;
      end
      MODE_COMMON:
      begin
        m.c1Inv = SRC_PIN0; // R12
        m.c2Inv = SRC_PIN1; // R12
        m.c1NonInv = SRC_PIN2; // R12
        m.c2NonInv = SRC_PIN2; // R12
        m.cmpPowerEn = 2'h3;
        m.analogPinEn = 4'h7;
      end
      MODE_INDEP:
      begin
        m.c1Inv = SRC_PIN0;
        m.c1NonInv = SRC_PIN3;
        m.c2Inv = SRC_PIN1;
        m.c2NonInv = SRC_PIN2;
        m.cmpPowerEn = 2'h3;
        m.analogPinEn = 4'hf;
      end
      MODE_ONE:
      begin
        m.c2Inv = SRC_PIN1;
        m.c2NonInv = SRC_PIN2;
        m.cmpPowerEn = 2'h2;
        m.analogPinEn = 4'h6;
      end
      MODE_OUTPIN:
      begin
        m.c1Inv = SRC_PIN0;
        m.c2Inv = SRC_PIN1;
        m.c1NonInv = SRC_PIN2;
        m.c2NonInv = SRC_PIN2;
        m.cmpPowerEn = 2'h3;
        m.analogPinEn = 4'h7;
        m.pinCmpOutSel = 2'h3; // R17
      end
      MODE_OFF:
      begin
        m.cmpPowerEn = 2'h0;
        m.analogPinEn = 4'h0;
      end
    endcase
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // synchroniser for the raw results

  dcc_sync u_sync
  (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .rawIn({cmp2Raw, cmp1Raw}), // R19
    .syncOut(syncRes)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next-state logic: bus slave, change detection, mux steering

  always_comb
  begin
    logic setupPh; // setup cycle seen
    logic accessPh; // access completes this edge
    logic ctlTouch; // control register read or written
    logic flagWr; // write to flag register
    logic mismatch; // results differ from reference
    dcc_sel_e sel; // decoded register
    logic [7:0] rdByte; // read value
    setupPh = 1'b0;
    accessPh = 1'b0;
    ctlTouch = 1'b0;
    flagWr = 1'b0;
    mismatch = 1'b0;
    sel = SEL_NONE;
    rdByte = 8'h00;
    s_d = s_q;

    // answer in the first access cycle, so pready drops otherwise
    s_d.rsp.pready = 1'b0;
    s_d.rsp.pslverr = 1'b0;
    setupPh = apbReq.psel && !apbReq.penable;
    accessPh = apbReq.psel && apbReq.penable && s_q.rsp.pready;
    sel = regSel(apbReq.paddr);

    // read mux; unused bits stay zero
    unique case (sel)
      SEL_CTL:
      begin
        rdByte[CTL_CMP2_BIT] = syncRes[1]; // R2
        rdByte[CTL_CMP1_BIT] = syncRes[0]; // R3
        rdByte[CTL_CIS_BIT] = s_q.inputSwitchSel; // R4
        rdByte[CTL_MODE_LSB +: MODE_W] = s_q.cmpModeSel;
      end
      SEL_DIR:
      begin
        rdByte[DIR_W-1:0] = s_q.portADirection;
      end
      SEL_FLAG:
      begin
        rdByte[FLAG_BIT] = s_q.cmpChangeFlag;
      end
      SEL_IEN:
      begin
        rdByte[IEN_CMP_BIT] = s_q.cmpChangeIrqEn;
        rdByte[IEN_PER_BIT] = s_q.peripheralIrqEn;
        rdByte[IEN_GLB_BIT] = s_q.globalIrqEn;
      end
      SEL_NONE:
      begin
        rdByte = 8'h00;
      end
    endcase

    // setup cycle: prepare answer for the access cycle
    if (setupPh)
    begin
      s_d.rsp.pready = 1'b1;
      s_d.rsp.pslverr = (sel == SEL_NONE);
      s_d.rsp.prdata = {24'h00_0000, rdByte};
    end

    // writes take effect at the completing edge only
    if (accessPh && apbReq.pwrite)
    begin
      unique case (sel)
        SEL_CTL:
        begin
          // result bits and bits 5..4 are not stored
          s_d.inputSwitchSel = apbReq.pwdata[CTL_CIS_BIT]; // R2 R3 R4
          s_d.cmpModeSel = apbReq.pwdata[CTL_MODE_LSB +: MODE_W]; // R7
        end
        SEL_DIR:
        begin
          s_d.portADirection = apbReq.pwdata[DIR_W-1:0]; // R9
        end
        SEL_FLAG:
        begin
          flagWr = 1'b1;
        end
        SEL_IEN:
        begin
          s_d.cmpChangeIrqEn = apbReq.pwdata[IEN_CMP_BIT];
          s_d.peripheralIrqEn = apbReq.pwdata[IEN_PER_BIT];
          s_d.globalIrqEn = apbReq.pwdata[IEN_GLB_BIT];
        end
        SEL_NONE:
        begin
          flagWr = 1'b0;
        end
      endcase
    end

    // any completed control access refreshes the reference
    ctlTouch = accessPh && (sel == SEL_CTL);
    if (ctlTouch)
    begin
      s_d.refResult = syncRes; // R13 R18
    end

    // flag: software write first, hardware set wins over a clear
    mismatch = (syncRes != s_q.refResult); // R14
    if (flagWr)
    begin
      s_d.cmpChangeFlag = apbReq.pwdata[FLAG_BIT];
    end
    if (mismatch)
    begin
      s_d.cmpChangeFlag = 1'b1; // R14 R15
    end

    // request gated by all three enables
    s_d.irqReq = s_d.cmpChangeFlag && s_d.cmpChangeIrqEn && s_d.peripheralIrqEn && s_d.globalIrqEn; // R15

    // mux steering and pin enables follow the new settings
    s_d.mux = decodeMode(s_d.cmpModeSel, s_d.inputSwitchSel); // R7 R8
    s_d.outEn = ~s_d.portADirection; // R9
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= STATE_RST; // R16
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs, all from state flip-flops

  assign apbRsp = s_q.rsp;
  assign muxCtl = s_q.mux;
  assign portDir = s_q.portADirection;
  assign portOutEn = s_q.outEn;
  assign cmpChangeFlag = s_q.cmpChangeFlag;
  assign cmpIrqReq = s_q.irqReq;

endmodule
`default_nettype wire

// ---- testbench/dcc_top_sva.sv ----
/*
  port checker of the dual comparator control block.
  assumes it is bound onto dcc_top, zero-wait apb, control at byte 07c.
*/
`timescale 1ns/10ps
`default_nettype none
module dcc_top_sva
(
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // watched ports
  input wire dcc_pkg::dcc_apb_req_s apbReq,
  input wire dcc_pkg::dcc_apb_rsp_s apbRsp,
  input wire dcc_pkg::dcc_mux_s muxCtl,
  input wire logic [4:0] portDir,
  input wire logic [4:0] portOutEn,
  input wire logic cmpChangeFlag,
  input wire logic cmpIrqReq
);
  import dcc_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // completed transfer and control write
  wire logic done = apbReq.psel && apbReq.penable && apbRsp.pready;
  wire logic ctlWr = done && apbReq.pwrite && apbReq.paddr == 12'h07c;
  wire logic [3:0] wr = apbReq.pwdata[3:0];
  ////////////////////////////////////////////////////////////////////////////////
  zero_wait_a: assert property (apbReq.psel && !apbReq.penable |=> apbRsp.pready)
    else $error("no ready after setup");
  err_ready_a: assert property (apbRsp.pslverr |-> apbRsp.pready)
    else $error("error without ready");
  ctl_read_a: assert property (done && !apbReq.pwrite && apbReq.paddr == 12'h07c |->
    apbRsp.prdata[31:8] == 24'h0 && apbRsp.prdata[5:4] == 2'h0) else $error("bad control read");
  out_enable_a: assert property (portOutEn == ~portDir) else $error("enable not from direction");
  irq_flag_a: assert property (cmpIrqReq |-> cmpChangeFlag) else $error("request without flag");
  flag_sticky_a: assert property ($fell(cmpChangeFlag) |->
    $past(done && apbReq.pwrite && apbReq.paddr == 12'h100)) else $error("flag dropped alone");
  mode_one_a: assert property (ctlWr && wr[2:0] == 3'h1 |=>
    muxCtl.c1Inv == ($past(wr[3]) ? SRC_PIN3 : SRC_PIN0)) else $error("switch mode one");
  mode_two_a: assert property (ctlWr && wr[2:0] == 3'h2 |=> muxCtl.c1Inv == ($past(wr[3]) ? SRC_PIN3 : SRC_PIN0)
    && muxCtl.c2Inv == ($past(wr[3]) ? SRC_PIN2 : SRC_PIN1)) else $error("switch mode two");
  common_pin_a: assert property (ctlWr && wr[2:0] == 3'h3 |=> muxCtl.c1Inv == SRC_PIN0 &&
    muxCtl.c2Inv == SRC_PIN1 && muxCtl.c1NonInv == SRC_PIN2 && muxCtl.c2NonInv == SRC_PIN2)
    else $error("common mode routing");
  out_pins_a: assert property (ctlWr && wr[2:0] == 3'h6 |=> muxCtl.pinCmpOutSel == 2'h3)
    else $error("result pins not routed");
  // main scenarios
  cov_flag: cover property ($rose(cmpChangeFlag));
  cov_irq: cover property ($rose(cmpIrqReq));
  cov_err: cover property (apbRsp.pslverr);
endmodule
bind dcc_top dcc_top_sva u_dcc_top_sva (.core_clk(core_clk), .arst_n(arst_n), .apbReq(apbReq),
  .apbRsp(apbRsp), .muxCtl(muxCtl), .portDir(portDir), .portOutEn(portOutEn),
  .cmpChangeFlag(cmpChangeFlag), .cmpIrqReq(cmpIrqReq));
`default_nettype wire

// ---- testbench/testbench.sv ----
/*
  self-checking bench of the dual comparator control block.
  assumes the zero-wait apb slave and two-flop result path of dcc_top.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import dcc_pkg::*;
  logic core_clk, arst_n, cmp1Raw, cmp2Raw, cmpChangeFlag, cmpIrqReq, err;
  dcc_apb_req_s apbReq;
  dcc_apb_rsp_s apbRsp;
  dcc_mux_s muxCtl;
  logic [4:0] portDir, portOutEn;
  logic [31:0] rd, wd;
  int fails, n_checks, seed, m;
  int mdlCtl, mdlDir; // reference model of the stored control and direction fields
  // device under test
  dcc_top u_dcc_top (.core_clk(core_clk), .arst_n(arst_n), .apbReq(apbReq), .apbRsp(apbRsp),
    .cmp1Raw(cmp1Raw), .cmp2Raw(cmp2Raw), .muxCtl(muxCtl), .portDir(portDir),
    .portOutEn(portOutEn), .cmpChangeFlag(cmpChangeFlag), .cmpIrqReq(cmpIrqReq));
  ////////////////////////////////////////////////////////////////////////////////
  // clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer, result in rd and err
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    apbReq.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (apbRsp.pready !== 1'b1 && n < 20);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    // model: only stored fields follow a completed write, unmapped writes are ignored
    if (w && a == 12'h07c) mdlCtl = d[3:0];
    if (w && a == 12'h214) mdlDir = d[4:0];
    // a slave that never answers ends the run as a failure
    if (n >= 20)
    begin
      fails++;
      give_verdict();
    end
  endtask
  // verdict
  task give_verdict;
    $display("mismatches %0d checks %0d", fails, n_checks);
    if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #100000;
    fails++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    seed = 10977;
    mdlCtl = 0;
    mdlDir = 'h1f;
    arst_n = 1'b0;
    cmp1Raw = 1'b0;
    cmp2Raw = 1'b0;
    apbReq = '0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    chk(portDir, 5'h1f);
    chk(portOutEn, 5'h0);
    chk(muxCtl, MUX_RST);
    apb(1'b0, 12'h07c, 0);
    chk(rd, 32'h0);
    // keep all interrupt enables off while the mode changes
    apb(1'b1, 12'h104, 0);
    // every mode, random results and junk in unused bits
    for (m = 0; m < 8; m++)
    begin
      wd = $random(seed);
      cmp1Raw <= wd[4];
      cmp2Raw <= wd[5];
      wd[2:0] = m[2:0];
      apb(1'b1, 12'h07c, wd);
      repeat (4) @(posedge core_clk);
      apb(1'b0, 12'h07c, 0);
      chk(rd, {24'h0, wd[5:4], 2'h0, wd[3:0]});
      chk(rd[3:0], mdlCtl);
      case (m)
        1: chk(muxCtl.c1Inv, wd[3] ? SRC_PIN3 : SRC_PIN0);
        2: chk({muxCtl.c1Inv, muxCtl.c2Inv, muxCtl.c1NonInv},
          {wd[3] ? SRC_PIN3 : SRC_PIN0, wd[3] ? SRC_PIN2 : SRC_PIN1, SRC_VREF});
        3: chk({muxCtl.c1Inv, muxCtl.c2Inv, muxCtl.c1NonInv}, {SRC_PIN0, SRC_PIN1, SRC_PIN2});
        6: chk(muxCtl.pinCmpOutSel, 2'h3);
        default: chk(muxCtl.cmpPowerEn !== 2'h0, m != 0 && m != 7);
      endcase
    end
    // unmapped place is refused
    apb(1'b0, 12'h300, 0);
    chk({err, rd[30:0]}, 32'h80000000);
    // direction register
    wd = $random(seed);
    apb(1'b1, 12'h214, wd);
    apb(1'b0, 12'h214, 0);
    chk(rd, {27'h0, wd[4:0]});
    chk(portOutEn ^ wd[4:0], 5'h1f);
    chk(portDir, mdlDir);
    // change flag: latch, clear, mismatch, persist, end by read
    apb(1'b0, 12'h07c, 0);
    apb(1'b1, 12'h100, 0);
    repeat (2) @(posedge core_clk);
    chk(cmpChangeFlag, 1'b0);
    cmp1Raw <= ~cmp1Raw;
    // two synchroniser stages pass before the change can reach the flag
    repeat (2) @(posedge core_clk);
    chk(cmpChangeFlag, 1'b0);
    repeat (4) @(posedge core_clk);
    chk(cmpChangeFlag, 1'b1);
    apb(1'b1, 12'h100, 0);
    repeat (2) @(posedge core_clk);
    chk(cmpChangeFlag, 1'b1);
    apb(1'b0, 12'h07c, 0);
    chk(rd[6], cmp1Raw);
    apb(1'b1, 12'h100, 0);
    repeat (2) @(posedge core_clk);
    chk(cmpChangeFlag, 1'b0);
    // interrupt request needs all three enables
    apb(1'b1, 12'h104, 7);
    apb(1'b1, 12'h100, 1);
    repeat (2) @(posedge core_clk);
    chk(cmpIrqReq, 1'b1);
    apb(1'b1, 12'h104, 3);
    repeat (2) @(posedge core_clk);
    chk({cmpIrqReq, cmpChangeFlag}, 2'h1);
    give_verdict();
  end
endmodule
`default_nettype wire
